// ---- rtl/sicr_cfg.svh ----
// Offsets, field positions and reset values of the control register bank.
`ifndef SICR_CFG_SVH
`define SICR_CFG_SVH

// Register indices; the byte address is four times the index.
`define SICR_IDX_CTRL 5'h00
`define SICR_IDX_RSTAT 5'h01
`define SICR_IDX_SCR0 5'h02
`define SICR_IDX_HIDH 5'h06
`define SICR_IDX_HIDL 5'h07
`define SICR_IDX_PWR 5'h08
`define SICR_IDX_CLKOUT 5'h0A
`define SICR_IDX_PCR 5'h0B
`define SICR_IDX_PCE0 5'h0C
`define SICR_IDX_PCE1 5'h0D
`define SICR_IDX_SD0 5'h0E
`define SICR_IDX_SD1 5'h0F
`define SICR_IDX_IOSH 5'h10
`define SICR_IDX_IOSL 5'h11
`define SICR_IDX_PROT 5'h12
`define SICR_IDX_GPA0 5'h13
`define SICR_IDX_GPB0 5'h15
`define SICR_IDX_GPB1 5'h16
`define SICR_IDX_ISS0 5'h18
`define SICR_IDX_ISS1 5'h19
`define SICR_IDX_ISS2 5'h1A

// Field positions in the control and reset cause registers.
`define SICR_CTRL_DBG 5
`define SICR_CTRL_SOFT_RESET_TRIGGER 4
`define SICR_CTRL_STOP_LSB 2
`define SICR_CTRL_WAIT_LSB 0
`define SICR_RSTAT_SWR 6
`define SICR_RSTAT_TOR 5
`define SICR_RSTAT_LOR 4
`define SICR_RSTAT_EXT 3
`define SICR_RSTAT_POR 2

// Reset values.
`define SICR_CTRL_RST 16'h0000
`define SICR_RSTAT_RST 16'h0004
`define SICR_WORD_RST 16'h0000
`define SICR_FIELD_RST 2'h0

`endif

// ---- rtl/sicr_pkg.sv ----
// Types shared by the control register bank files.
`default_nettype none
package sicr_pkg;

  // One register word of the bank.
  typedef logic [15:0] sicr_word_t;

  // Two-bit field whose upper bit locks it until the next reset.
  typedef logic [1:0] sicr_field_t;

endpackage : sicr_pkg
`default_nettype wire

// ---- rtl/sicr_lock_field.sv ----
// Two-bit control field that write-protects itself when its upper bit is set.
`timescale 1ns/1ns
`default_nettype none
`include "sicr_cfg.svh"
module sicr_lock_field (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Internal reset event and write port.
  input wire logic clrEvt,
  input wire logic wrEn,
  input wire sicr_pkg::sicr_field_t wrVal,
  // Current field value.
  output var sicr_pkg::sicr_field_t field_ff
);

  // A set upper bit ignores writes until any reset clears the field.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      field_ff <= `SICR_FIELD_RST;
    end else if (clrEvt) begin
      field_ff <= `SICR_FIELD_RST;
    end else if (wrEn && !field_ff[1]) begin
      field_ff <= wrVal;
    end
  end

  // A locked field holds until a reset event.
  field_lock_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    (field_ff[1] && !clrEvt) |=> (field_ff == $past(field_ff)))
    else $error("Locked field changed without a reset.");

  // An unlocked field takes the written value on the next edge.
  field_write_take_a: assert property (@(posedge clk) disable iff (!rstn)
    (wrEn && !field_ff[1] && !clrEvt) |=> (field_ff == $past(wrVal)))
    else $error("Unlocked field did not take a write.");

endmodule : sicr_lock_field
`default_nettype wire

// ---- rtl/sicr_axil_slave.sv ----
// AXI4-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/1ns
`default_nettype none
module sicr_axil_slave #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Write address and data channels.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  // Write response channel.
  output var logic [1:0] s_axi_bresp,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address and data channels.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  output var logic [31:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side strobes.
  output logic wrEn,
  output var logic [ADDR_W-1:0] wrAddr_ff,
  output var logic [15:0] wrData_ff,
  output var logic [1:0] wrStrb_ff,
  output logic rdEn,
  output var logic [ADDR_W-1:0] rdAddr_ff,
  input wire logic [15:0] rdData
);

  logic awHeld_ff;
  logic wHeld_ff;
  logic arHeld_ff;

  // A write fires once both halves are held and the last response is gone.
  assign wrEn = awHeld_ff && wHeld_ff && !s_axi_bvalid;
  assign rdEn = arHeld_ff;

  // Write address and data are taken independently, in either order.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      wrAddr_ff <= '0;
      wrData_ff <= 16'h0000;
      wrStrb_ff <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_ff <= 1'b1;
        s_axi_awready <= 1'b0;
        wrAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_ff <= 1'b1;
        s_axi_wready <= 1'b0;
        wrData_ff <= s_axi_wdata[15:0];
        wrStrb_ff <= s_axi_wstrb[1:0];
      end
      if (wrEn) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // The write response follows the register update and always reports okay.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (wrEn) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // One read at a time; the data word is captured a cycle after the address.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arHeld_ff <= 1'b0;
      s_axi_arready <= 1'b1;
      rdAddr_ff <= '0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        arHeld_ff <= 1'b1;
        s_axi_arready <= 1'b0;
        rdAddr_ff <= s_axi_araddr;
      end
      if (rdEn) begin
        arHeld_ff <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, rdData};
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : sicr_axil_slave
`default_nettype wire

// ---- rtl/sicr_regs.sv ----
// Control and status register bank of the system integration unit.
//
// Functional notes
// - Debug clock force bit keeps debug clock running.
// - Writing soft reset bit resets; reads zero.
// - Halt-block field 00 allows, 01 blocks Stop.
// - Halt-block values 10, 11 also lock field.
// - Idle-block field gates Wait, locks likewise.
// - Soft reset sets software reset cause flag unless another cause coincides.
// - Unmapped writes do nothing; unmapped reads zero.
`timescale 1ns/1ns
`default_nettype none
`include "sicr_cfg.svh"
module sicr_regs #(
  parameter int ADDR_W = 8,
  parameter logic [15:0] CHIP_ID_HI = 16'h0A5C, // Arbitrary value.
  parameter logic [15:0] CHIP_ID_LO = 16'h3E01  // Arbitrary value.
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // AXI4-Lite write channels.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  output var logic [1:0] s_axi_bresp,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  output var logic [31:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core and system status inputs.
  input wire logic tapEnabled,
  input wire logic coreStopInstr,
  input wire logic coreWaitInstr,
  input wire logic extResetEvt,
  input wire logic copLorEvt,
  input wire logic copTorEvt,
  // Control outputs.
  output var logic debugClockEn_ff,
  output var logic enterStop_ff,
  output var logic enterWait_ff,
  output var logic regStandby_ff,
  output var logic sysResetReq_ff
);

  localparam int NUM_GEN = 15;
  localparam int NUM_SCR = 4;

  // Plain storage registers, in index order.
  localparam logic [4:0] GEN_IDX [NUM_GEN] = '{
    `SICR_IDX_CLKOUT, `SICR_IDX_PCR, `SICR_IDX_PCE0, `SICR_IDX_PCE1, `SICR_IDX_SD0,
    `SICR_IDX_SD1, `SICR_IDX_IOSH, `SICR_IDX_IOSL, `SICR_IDX_PROT, `SICR_IDX_GPA0,
    `SICR_IDX_GPB0, `SICR_IDX_GPB1, `SICR_IDX_ISS0, `SICR_IDX_ISS1, `SICR_IDX_ISS2
  };

  logic wrEn;
  logic rdEn;
  logic [ADDR_W-1:0] wrAddr_ff;
  logic [ADDR_W-1:0] rdAddr_ff;
  logic [15:0] wrData_ff;
  logic [1:0] wrStrb_ff;
  sicr_pkg::sicr_word_t rdData;
  logic wrHit;
  logic rdHit;
  logic [4:0] wrIdx;
  logic [4:0] rdIdx;
  logic wrCtrl;
  logic wrPwr;
  logic swTrig;
  logic resetEvt;
  sicr_pkg::sicr_word_t ctrlView;
  sicr_pkg::sicr_word_t ctrlNew;
  sicr_pkg::sicr_word_t pwrNew;
  logic dbgForce_ff;
  sicr_pkg::sicr_field_t stopField_ff;
  sicr_pkg::sicr_field_t waitField_ff;
  sicr_pkg::sicr_field_t pwrField_ff;
  sicr_pkg::sicr_word_t rstat_ff;
  sicr_pkg::sicr_word_t scratch_ff [NUM_SCR];
  sicr_pkg::sicr_word_t genReg_ff [NUM_GEN];

  // Merges a bus write into a word under its two byte strobes.
  function automatic sicr_pkg::sicr_word_t mergeWord(
    input sicr_pkg::sicr_word_t oldVal,
    input logic [15:0] data,
    input logic [1:0] strb
  );
    sicr_pkg::sicr_word_t res;
    res = oldVal;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : mergeWord

  //////////////////////////////////////////////////////////////////////////////////////////
  // Bus front end.
  //////////////////////////////////////////////////////////////////////////////////////////

  // Converts AXI4-Lite transfers into one-cycle write and read strobes.
  sicr_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
    .clk(clk),
    .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wrEn(wrEn),
    .wrAddr_ff(wrAddr_ff),
    .wrData_ff(wrData_ff),
    .wrStrb_ff(wrStrb_ff),
    .rdEn(rdEn),
    .rdAddr_ff(rdAddr_ff),
    .rdData(rdData)
  );

  // Address decode; anything above the bank's word range is unmapped.
  always_comb begin
    wrIdx = wrAddr_ff[6:2];
    rdIdx = rdAddr_ff[6:2];
    wrHit = wrEn && ((wrAddr_ff >> 7) == '0);
    rdHit = (rdAddr_ff >> 7) == '0;
    wrCtrl = wrHit && (wrIdx == `SICR_IDX_CTRL);
    wrPwr = wrHit && (wrIdx == `SICR_IDX_PWR);
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Control register.
  //////////////////////////////////////////////////////////////////////////////////////////

  // Current control view; reserved bits and the trigger bit read as zero.
  always_comb begin
    ctrlView = `SICR_CTRL_RST;
    ctrlView[`SICR_CTRL_DBG] = dbgForce_ff;
    ctrlView[`SICR_CTRL_STOP_LSB +: 2] = stopField_ff;
    ctrlView[`SICR_CTRL_WAIT_LSB +: 2] = waitField_ff;
    ctrlNew = mergeWord(ctrlView, wrData_ff, wrStrb_ff);
    pwrNew = mergeWord({14'h0000, pwrField_ff}, wrData_ff, wrStrb_ff);
    swTrig = wrCtrl && ctrlNew[`SICR_CTRL_SOFT_RESET_TRIGGER];
    resetEvt = extResetEvt || copLorEvt || copTorEvt || swTrig;
  end

  // Debug clock force bit, cleared by any reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dbgForce_ff <= 1'b0;
    end else if (resetEvt) begin
      dbgForce_ff <= 1'b0;
    end else if (wrCtrl) begin
      dbgForce_ff <= ctrlNew[`SICR_CTRL_DBG];
    end
  end

  // Halt-block field for Stop entry.
  sicr_lock_field u_stop (
    .clk(clk),
    .rstn(rstn),
    .clrEvt(resetEvt),
    .wrEn(wrCtrl),
    .wrVal(ctrlNew[`SICR_CTRL_STOP_LSB +: 2]),
    .field_ff(stopField_ff)
  );

  // Idle-block field for Wait entry.
  sicr_lock_field u_wait (
    .clk(clk),
    .rstn(rstn),
    .clrEvt(resetEvt),
    .wrEn(wrCtrl),
    .wrVal(ctrlNew[`SICR_CTRL_WAIT_LSB +: 2]),
    .field_ff(waitField_ff)
  );

  // Regulator standby field with the same lock behaviour.
  sicr_lock_field u_pwr (
    .clk(clk),
    .rstn(rstn),
    .clrEvt(resetEvt),
    .wrEn(wrPwr),
    .wrVal(pwrNew[1:0]),
    .field_ff(pwrField_ff)
  );

  //////////////////////////////////////////////////////////////////////////////////////////
  // Core-facing outputs.
  //////////////////////////////////////////////////////////////////////////////////////////

  // Debug clock runs with the test port, or always when forced.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      debugClockEn_ff <= 1'b0;
    end else begin
      debugClockEn_ff <= dbgForce_ff || tapEnabled;
    end
  end

  // Halt and idle instructions enter low-power modes only when allowed.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enterStop_ff <= 1'b0;
      enterWait_ff <= 1'b0;
      regStandby_ff <= 1'b0;
    end else begin
      enterStop_ff <= coreStopInstr && !stopField_ff[0];
      enterWait_ff <= coreWaitInstr && !waitField_ff[0];
      regStandby_ff <= pwrField_ff[0];
    end
  end

  // Device reset request, one cycle per reset event.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sysResetReq_ff <= 1'b0;
    end else begin
      sysResetReq_ff <= resetEvt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Reset cause, scratch and plain registers.
  //////////////////////////////////////////////////////////////////////////////////////////

  // Records the highest-precedence cause of the latest reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstat_ff <= `SICR_RSTAT_RST;
    end else if (resetEvt) begin
      rstat_ff <= `SICR_WORD_RST;
      if (extResetEvt) begin
        rstat_ff[`SICR_RSTAT_EXT] <= 1'b1;
      end else if (copLorEvt) begin
        rstat_ff[`SICR_RSTAT_LOR] <= 1'b1;
      end else if (copTorEvt) begin
        rstat_ff[`SICR_RSTAT_TOR] <= 1'b1;
      end else begin
        rstat_ff[`SICR_RSTAT_SWR] <= 1'b1;
      end
    end
  end

  // Scratch words survive every reset except power-on.
  for (genvar s = 0; s < NUM_SCR; s++) begin : g_scr
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        scratch_ff[s] <= `SICR_WORD_RST;
      end else if (wrHit && (wrIdx == `SICR_IDX_SCR0 + 5'(s))) begin
        scratch_ff[s] <= mergeWord(scratch_ff[s], wrData_ff, wrStrb_ff);
      end
    end
  end

  // Plain storage registers, cleared by any reset.
  for (genvar g = 0; g < NUM_GEN; g++) begin : g_gen
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        genReg_ff[g] <= `SICR_WORD_RST;
      end else if (resetEvt) begin
        genReg_ff[g] <= `SICR_WORD_RST;
      end else if (wrHit && (wrIdx == GEN_IDX[g])) begin
        genReg_ff[g] <= mergeWord(genReg_ff[g], wrData_ff, wrStrb_ff);
      end
    end
  end

  // Read mux; unmapped addresses read as zero.
  always_comb begin
    rdData = `SICR_WORD_RST;
    if (rdHit) begin
      case (rdIdx)
        `SICR_IDX_CTRL: rdData = ctrlView;
        `SICR_IDX_RSTAT: rdData = rstat_ff;
        `SICR_IDX_HIDH: rdData = CHIP_ID_HI;
        `SICR_IDX_HIDL: rdData = CHIP_ID_LO;
        `SICR_IDX_PWR: rdData = {14'h0000, pwrField_ff};
        default: begin
          for (int i = 0; i < NUM_SCR; i++) begin
            if (rdIdx == `SICR_IDX_SCR0 + 5'(i)) begin
              rdData = scratch_ff[i];
            end
          end
          for (int j = 0; j < NUM_GEN; j++) begin
            if (rdIdx == GEN_IDX[j]) begin
              rdData = genReg_ff[j];
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Checks.
  //////////////////////////////////////////////////////////////////////////////////////////

  // Without force or test port the debug clock is off a cycle later.
  dbg_clock_gate_a: assert property (@(posedge clk) disable iff (!rstn)
    (!dbgForce_ff && !tapEnabled) |=> !debugClockEn_ff)
    else $error("Debug clock ran without force or test port.");

  // A set force bit keeps the debug clock on.
  dbg_clock_force_a: assert property (@(posedge clk) disable iff (!rstn)
    dbgForce_ff |=> debugClockEn_ff)
    else $error("Forced debug clock stopped.");

  // A soft reset write requests a device reset and reads back zero.
  soft_reset_req_a: assert property (@(posedge clk) disable iff (!rstn)
    swTrig |=> (sysResetReq_ff && !ctrlView[`SICR_CTRL_SOFT_RESET_TRIGGER] && dbgForce_ff == 1'b0))
    else $error("Soft reset write did not reset the device.");

  // Control reads return zero in the trigger bit with the answer a cycle later.
  ctrl_read_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    (rdEn && rdHit && rdIdx == `SICR_IDX_CTRL) |=> (s_axi_rvalid && !s_axi_rdata[4]))
    else $error("Control read showed the trigger bit.");

  // Halt with the field clear enters Stop; with bit 0 set it does not.
  stop_gate_a: assert property (@(posedge clk) disable iff (!rstn)
    coreStopInstr |=> (enterStop_ff == !$past(stopField_ff[0])))
    else $error("Stop entry disagrees with the halt-block field.");

  // A locked halt-block field survives a control write.
  stop_lock_a: assert property (@(posedge clk) disable iff (!rstn)
    (stopField_ff[1] && wrCtrl && !resetEvt) |=> $stable(stopField_ff))
    else $error("Locked halt-block field was written.");

  // Idle with the field clear enters Wait; with bit 0 set it does not.
  wait_gate_a: assert property (@(posedge clk) disable iff (!rstn)
    coreWaitInstr |=> (enterWait_ff == !$past(waitField_ff[0])))
    else $error("Wait entry disagrees with the idle-block field.");

  // A lone soft reset leaves only the software flag set.
  sw_cause_a: assert property (@(posedge clk) disable iff (!rstn)
    (swTrig && !extResetEvt && !copLorEvt && !copTorEvt) |=> (rstat_ff == 16'h0040))
    else $error("Soft reset cause not recorded.");

  // A write to an unmapped offset leaves the control state alone.
  unmapped_write_a: assert property (@(posedge clk) disable iff (!rstn)
    (wrEn && (!wrHit || wrIdx > `SICR_IDX_ISS2) && !resetEvt)
      |=> ($stable(ctrlView) && $stable(scratch_ff[0])))
    else $error("Unmapped write changed a register.");

  // With both fields locked the debug bit stays writable.
  locked_rest_a: assert property (@(posedge clk) disable iff (!rstn)
    (stopField_ff[1] && waitField_ff[1] && wrCtrl && !resetEvt && wrStrb_ff[0])
      |=> (dbgForce_ff == $past(wrData_ff[`SICR_CTRL_DBG])))
    else $error("Locked fields blocked the rest of the control register.");

  // Main scenarios.
  soft_reset_c: cover property (@(posedge clk) disable iff (!rstn) swTrig);
  stop_locked_c: cover property (@(posedge clk) disable iff (!rstn) stopField_ff == 2'h3);
  stop_entry_c: cover property (@(posedge clk) disable iff (!rstn) enterStop_ff);
  wait_blocked_c: cover property (@(posedge clk) disable iff (!rstn)
    coreWaitInstr && waitField_ff[0]);

endmodule : sicr_regs
`default_nettype wire

// ---- testbench/sicr_host_model.sv ----
// Bus master model standing in for core software on the register bus.
`timescale 1ns/1ns
`default_nettype none
module sicr_host_model (
  // Clock.
  input wire logic clk,
  // Write channels.
  output var logic [7:0] awAddr,
  output var logic awValid,
  input wire logic awReady,
  output var logic [31:0] wData,
  output var logic wValid,
  input wire logic wReady,
  input wire logic bValid,
  output var logic bReady,
  // Read channels.
  output var logic [7:0] arAddr,
  output var logic arValid,
  input wire logic arReady,
  input wire logic [31:0] rData,
  input wire logic rValid,
  output var logic rReady
);
  // Bus is idle at time zero.
  initial begin
    {awAddr, awValid, wData, wValid, bReady} = '0;
    {arAddr, arValid, rReady} = '0;
  end

  // One word write; callers keep reserved control bits zero.
  task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    @(posedge clk);
    awAddr <= {1'b0, idx, 2'b00};
    wData <= {16'h0000, d};
    {awValid, wValid, bReady} <= 3'h7;
    do begin
      @(posedge clk);
      if (awValid && awReady) begin
        awValid <= 1'b0;
        awAddr <= ~awAddr;
      end
      if (wValid && wReady) begin
        wValid <= 1'b0;
        wData <= ~wData;
      end
    end while (!bValid);
    bReady <= 1'b0;
  endtask : wr

  // One word read; the answer is taken at the edge where rvalid is seen.
  task automatic rd(input logic [4:0] idx, output logic [15:0] d);
    @(posedge clk);
    araddr_set: arAddr <= {1'b0, idx, 2'b00};
    {arValid, rReady} <= 2'h3;
    do begin
      @(posedge clk);
      if (arValid && arReady) begin
        arValid <= 1'b0;
        arAddr <= ~arAddr;
      end
    end while (!rValid);
    d = rData[15:0];
    rReady <= 1'b0;
  endtask : rd
endmodule : sicr_host_model
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the control register bank.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk, rstn, tapEnabled, coreStopInstr, coreWaitInstr, extResetEvt;
  logic [7:0] awAddr, arAddr;
  logic [31:0] wData, rData;
  logic awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
  logic dbgEn, stopEn, waitEn, stbyEn, rstReq;
  logic [15:0] rv;
  logic [1:0] bResp, rResp;
  int error_cnt, cmp_count, rstCnt;
  int mdl [32];
  //////////////////////////////////////////////////////////////////////////////
  // Clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Identity values are arbitrary.
  sicr_regs #(.CHIP_ID_HI(16'h5A17), .CHIP_ID_LO(16'h0C3B)) dut (.clk(clk), .rstn(rstn),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .tapEnabled(tapEnabled),
    .coreStopInstr(coreStopInstr), .coreWaitInstr(coreWaitInstr), .extResetEvt(extResetEvt),
    .copLorEvt(1'b0), .copTorEvt(1'b0), .debugClockEn_ff(dbgEn), .enterStop_ff(stopEn),
    .enterWait_ff(waitEn), .regStandby_ff(stbyEn), .sysResetReq_ff(rstReq));

  // Software side.
  sicr_host_model host (.clk(clk), .awAddr(awAddr), .awValid(awValid), .awReady(awReady),
    .wData(wData), .wValid(wValid), .wReady(wReady), .bValid(bValid), .bReady(bReady),
    .arAddr(arAddr), .arValid(arValid), .arReady(arReady), .rData(rData), .rValid(rValid),
    .rReady(rReady));

  // Counts reset request pulses on the falling edge, clear of the edge that launches them.
  always @(negedge clk) if (rstReq === 1'b1) rstCnt++;
  //////////////////////////////////////////////////////////////////////////////
  // Compare tasks for words and single outputs.
  task automatic chkW(input logic [15:0] got, input int exp);
    cmp_count++;
    if (got !== exp[15:0]) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp[15:0]);
    end
  endtask : chkW

  task automatic chkB(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chkB

  // Model of a reset event inside the bank; scratch words survive.
  function automatic void mdlRst(input int cause);
    mdl[0] = 0;
    mdl[1] = cause;
    mdl[8] = 0;
    for (int k = 10; k < 27; k++) mdl[k] = 0;
  endfunction : mdlRst

  // Model of one register write.
  function automatic void mdlWr(input int i, input int d);
    if (i == 0 && d[4]) mdlRst(16'h0040);
    else if (i == 0) mdl[0] = (d & 16'h0020) | (mdl[0][3] ? mdl[0] & 16'h000C : d & 16'h000C)
      | (mdl[0][1] ? mdl[0] & 16'h0003 : d & 16'h0003);
    else if (i == 8) mdl[8] = mdl[8][1] ? mdl[8] : d & 16'h0003;
    else if ((i >= 2 && i <= 5) || (i >= 10 && i <= 26 && i != 20 && i != 23)) mdl[i] = d[15:0];
  endfunction : mdlWr

  // Bus write mirrored in the model, and checked read.
  task automatic wrM(input int i, input int d);
    host.wr(i[4:0], d[15:0]);
    chkW({14'h0000, bResp}, 0);
    mdlWr(i, d);
  endtask : wrM

  task automatic rdChk(input int i);
    host.rd(i[4:0], rv);
    chkW(rv, mdl[i]);
    chkW(rData[31:16] | {14'h0000, rResp}, 0);
  endtask : rdChk

  // Fires both core instructions and checks the debug clock, Stop, Wait and standby outputs.
  task automatic coreChk;
    @(posedge clk);
    {coreStopInstr, coreWaitInstr} <= 2'h3;
    tapEnabled <= 1'($urandom);
    @(posedge clk);
    {coreStopInstr, coreWaitInstr} <= 2'h0;
    #1;
    chkB(stopEn, !mdl[0][2]);
    chkB(waitEn, !mdl[0][0]);
    chkB(dbgEn, mdl[0][5] | tapEnabled);
    chkB(stbyEn, mdl[8][0]);
  endtask : coreChk

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {rstn, tapEnabled, coreStopInstr, coreWaitInstr, extResetEvt} = '0;
    {error_cnt, cmp_count, rstCnt} = '0;
    void'($urandom(33298));
    foreach (mdl[k]) mdl[k] = 0;
    mdl[1] = 16'h0004;
    mdl[6] = 16'h5A17;
    mdl[7] = 16'h0C3B;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int k = 0; k < 32; k++) rdChk(k);
    $display("test reset_values done");
    for (int k = 2; k < 32; k++) wrM(k, $urandom);
    for (int k = 0; k < 32; k++) rdChk(k);
    $display("test random_fill done");
    wrM(0, 16'h0025);
    rdChk(0);
    coreChk();
    wrM(0, 16'h000A);
    coreChk();
    wrM(0, 16'h0025);
    rdChk(0);
    coreChk();
    $display("test field_locks done");
    wrM(0, 16'h0010);
    chkW(rstCnt[15:0], 1);
    for (int k = 0; k < 32; k++) rdChk(k);
    wrM(0, 16'h0005);
    rdChk(0);
    coreChk();
    $display("test soft_reset done");
    @(posedge clk) extResetEvt <= 1'b1;
    @(posedge clk) extResetEvt <= 1'b0;
    mdlRst(16'h0008);
    rdChk(1);
    rdChk(0);
    chkW(rstCnt[15:0], 2);
    wrM(0, 16'h0000);
    coreChk();
    $display("test ext_reset done");
    test_done();
  end

  // Watchdog.
  initial begin
    #400000;
    error_cnt++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
